// File: tb/dcm_asserts.sv
`timescale 1ns/1ps
module dcm_checker (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic first_port_serial_in,
	input wire logic first_port_serial_out,
	input wire logic second_port_serial_in,
	input wire logic second_port_serial_out,
	input wire logic second_port_send_request,
	input wire logic first_port_send_lamp,
	input wire logic first_port_receive_lamp,
	input wire logic first_port_error_lamp,
	input wire logic second_port_send_lamp,
	input wire logic second_port_receive_lamp,
	input wire logic second_port_error_lamp
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_tx1_lamp_on: assert property (
		$fell(first_port_serial_out) |-> ##[0:2] first_port_send_lamp)
		else $error("port one send lamp dark");
	a_tx1_lamp_off: assert property (
		$fell(first_port_send_lamp) |-> first_port_serial_out)
		else $error("port one send lamp off mid frame");
	a_rx1_lamp_on: assert property (
		$fell(first_port_serial_in) |-> ##[0:4] first_port_receive_lamp)
		else $error("port one receive lamp dark");
	a_tx2_lamp_on: assert property (
		$fell(second_port_serial_out) |-> ##[0:2] second_port_send_lamp)
		else $error("port two send lamp dark");
	a_rx2_lamp_on: assert property (
		$fell(second_port_serial_in) |-> ##[0:4] second_port_receive_lamp)
		else $error("port two receive lamp dark");
	a_tx2_needs_request: assert property (
		$fell(second_port_serial_out) |-> second_port_send_request)
		else $error("port two sent without request");
	a_request_first: assert property (
		$rose(second_port_send_request) |-> second_port_serial_out)
		else $error("port two line busy as request rose");
	a_idle_no_request: assert property (
		!second_port_send_request |-> second_port_serial_out)
		else $error("port two line low without request");
	a_err1_stretch: assert property (
		$rose(first_port_error_lamp) |=> first_port_error_lamp[*8])
		else $error("port one error lamp too short");
	a_err2_stretch: assert property (
		$rose(second_port_error_lamp) |=> second_port_error_lamp[*8])
		else $error("port two error lamp too short");
endmodule : dcm_checker

bind dual_port_serial_comm_module dcm_checker u_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.first_port_serial_in(first_port_serial_in),
	.first_port_serial_out(first_port_serial_out),
	.second_port_serial_in(second_port_serial_in),
	.second_port_serial_out(second_port_serial_out),
	.second_port_send_request(second_port_send_request),
	.first_port_send_lamp(first_port_send_lamp),
	.first_port_receive_lamp(first_port_receive_lamp),
	.first_port_error_lamp(first_port_error_lamp),
	.second_port_send_lamp(second_port_send_lamp),
	.second_port_receive_lamp(second_port_receive_lamp),
	.second_port_error_lamp(second_port_error_lamp)
);

// File: tb/dual_port_serial_comm_module_tb.sv
`timescale 1ns/1ps
module dual_port_serial_comm_module_tb;
	import dcm_pkg::*;
	localparam int LAMP = 20;
	localparam int DIV = 100_000_000 / 115200;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic p1_in, p1_out, p2_in, p2_out, rts, permit;
	logic [5:0] lamp;
	logic [15:0] rv;
	logic [7:0] b, got, c;
	logic ok;
	logic [7:0] codes [3] = '{8'h05, 8'h11, 8'hFA};
	time t_gap = 0;
	int n_errors = 0;
	int num_checks = 0;
	always #(CLK_NS / 2) clk_sys = ~clk_sys;
	dual_port_serial_comm_module #(.MS_CYCLES(10), .LAMP_CYCLES(LAMP)) u_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .first_port_serial_in(p1_in),
		.first_port_serial_out(p1_out), .second_port_serial_in(p2_in),
		.second_port_serial_out(p2_out), .second_port_send_request(rts),
		.second_port_send_permit(permit), .first_port_send_lamp(lamp[0]),
		.first_port_receive_lamp(lamp[1]), .first_port_error_lamp(lamp[2]),
		.second_port_send_lamp(lamp[3]), .second_port_receive_lamp(lamp[4]),
		.second_port_error_lamp(lamp[5]));
	far_station u_far (.clk_sys(clk_sys), .p1_tx(p1_out), .p2_tx(p2_out),
		.p2_request(rts), .p1_rx(p1_in), .p2_rx(p2_in), .p2_permit(permit));
	// ---------------------------------------------------------------
	// bus, compare and expectation helpers
	// ---------------------------------------------------------------
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
	endtask : rd
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// bounded: a stuck flag ends as a mismatch, not a hang
	task automatic poll(input int n);
		rv = 16'h0000;
		for (int k = 0; k < 400 && rv[n] !== 1'b1; k++)
			rd(REG_STATUS);
		check("status flag", {15'h0, rv[n]}, 16'h0001);
	endtask : poll
	function automatic logic [1:0] proto_of(input logic [7:0] c);
		if (c == 8'h05 || c == 8'h4E)
			return 2'h1;
		return (c != 8'h00 && c <= 8'hF7) ? 2'h2 : 2'h3;
	endfunction : proto_of
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (130_000) @(posedge clk_sys);
		n_errors++;
		tally_and_finish();
	end
	initial begin
		rv = 16'($urandom(45551));
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(REG_P1_CFG);
		check("p1 cfg", rv, P1_CFG_RST);
		rd(REG_P2_CFG);
		check("p2 cfg", rv, P2_CFG_RST);
		rd(REG_P2_TIMING);
		check("timing", rv, P2_TIMING_RST);
		rd(4'hF);
		check("hole", rv, 16'h0000);
		wr(REG_P1_CFG, 16'h0004);
		wr(REG_P2_TIMING, 16'h0102);
		b = 8'($urandom);
		c = 8'($urandom);
		// both directions of port one at once keeps the run short
		fork
			u_far.grab(1'b0, 8, 1, DIV, got, ok);
			wr(REG_TX1, {8'h00, b});
			u_far.send(1'b0, c, DIV);
		join
		check("tx1 byte", {8'h00, got}, {8'h00, b});
		check("tx1 stop", {15'h0, ok}, 16'h0001);
		poll(8);
		rd(REG_RX1);
		check("rx1", rv, {7'h00, 1'b1, c});
		rd(REG_RX1);
		check("rx1 cleared", {15'h0, rv[8]}, 16'h0000);
		wr(REG_CTRL, 16'h0001);
		rd(REG_STATUS);
		check("no master", {15'h0, rv[2]}, 16'h0000);
		wr(REG_P2_CFG, 16'h0078);
		wr(REG_CTRL, 16'h0001);
		rd(REG_STATUS);
		check("master", {15'h0, rv[2]}, 16'h0001);
		fork
			u_far.grab(1'b1, 7, 2, DIV, got, ok);
			wr(REG_TX2, {7'h00, 1'b1, b});
		join
		check("tx2 byte", {8'h00, got}, {9'h000, b[6:0]});
		check("tx2 stops", {15'h0, ok}, 16'h0001);
		rd(REG_STATUS);
		check("early timeout", {15'h0, rv[4]}, 16'h0000);
		poll(4);
		check("err lamp 2", {15'h0, lamp[5]}, 16'h0001);
		check("back to slave", {15'h0, rv[2]}, 16'h0000);
		wr(REG_STATUS, 16'h0010);
		rd(REG_STATUS);
		check("timeout clear", {15'h0, rv[4]}, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			repeat (LAMP + 8) @(posedge clk_sys);
			wr(REG_REPORT, 16'(1 << i));
			#1;
			check("report lamp", {15'h0, lamp[i < 3 ? 2 : 5]}, 16'h0001);
		end
		wr(REG_P2_CFG, 16'h0008);
		foreach (codes[i]) begin
			while ($time - t_gap < 35 * DIV * CLK_NS)
				@(posedge clk_sys);
			u_far.send(1'b1, codes[i], DIV);
			t_gap = $time;
			poll(9);
			check("proto", {14'h0, rv[7:6]}, {14'h0, proto_of(codes[i])});
			rd(REG_RX2);
			check("rx2", rv, {7'h00, 1'b1, codes[i]});
		end
		tally_and_finish();
	end
endmodule : dual_port_serial_comm_module_tb

// File: tb/far_station.sv
`timescale 1ns/1ps
module far_station (
	input wire logic clk_sys,
	input wire logic p1_tx,
	input wire logic p2_tx,
	input wire logic p2_request,
	output logic p1_rx,
	output logic p2_rx,
	output logic p2_permit
);
	logic [3:0] perm_q = 4'h0;
	initial begin
		p1_rx = 1'b1;
		p2_rx = 1'b1;
	end
	// slow modem: permit trails the request by four cycles
	always @(posedge clk_sys) begin
		perm_q <= {perm_q[2:0], p2_request};
	end
	assign p2_permit = perm_q[3];
	// ---------------------------------------------------------------
	// frames, lsb first, idle mark high
	// ---------------------------------------------------------------
	task automatic send(input logic port2, input logic [7:0] b,
		input int div);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		// start on an edge so the line moves with the design's clock
		@(posedge clk_sys);
		for (int i = 0; i < 10; i++) begin
			if (port2)
				p2_rx <= f[i];
			else
				p1_rx <= f[i];
			repeat (div) @(posedge clk_sys);
		end
	endtask : send
	task automatic grab(input logic port2, input int nbits,
		input int nstop, input int div, output logic [7:0] b,
		output logic ok);
		b = 8'h00;
		ok = 1'b1;
		if (port2)
			@(negedge p2_tx);
		else
			@(negedge p1_tx);
		repeat (div / 2) @(posedge clk_sys);
		for (int i = 0; i < nbits + nstop; i++) begin
			repeat (div) @(posedge clk_sys);
			if (i < nbits)
				b[i] = port2 ? p2_tx : p1_tx;
			else
				ok = ok & (port2 ? p2_tx : p1_tx);
		end
	endtask : grab
endmodule : far_station

// File: verilog/dcm_pkg.sv
package dcm_pkg;
	// ---------------------------------------------------------------
	// widths and clock
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int CLK_NS = 10;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int DIV_W = 20;
	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_P1_CFG = 4'h0;
	localparam logic [3:0] REG_P2_CFG = 4'h1;
	localparam logic [3:0] REG_P2_TIMING = 4'h2;
	localparam logic [3:0] REG_TX1 = 4'h3;
	localparam logic [3:0] REG_TX2 = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h5;
	localparam logic [3:0] REG_RX1 = 4'h6;
	localparam logic [3:0] REG_RX2 = 4'h7;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_REPORT = 4'h9;
	// ---------------------------------------------------------------
	// field positions
	// ---------------------------------------------------------------
	localparam int P2_DATA7_BIT = 4;
	localparam int P2_STOP2_BIT = 5;
	localparam int P2_MASTER_BIT = 6;
	localparam int P2_RAW_BIT = 7;
	localparam int TX2_LAST_BIT = 8;
	localparam int RX_VALID_BIT = 8;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_END_BIT = 1;
	localparam int ST_TMO_BIT = 4;
	localparam int ST_FE1_BIT = 10;
	localparam int ST_FE2_BIT = 11;
	// ---------------------------------------------------------------
	// reset values: 9600 baud, 8 data, 1 stop, slave
	// ---------------------------------------------------------------
	localparam logic [15:0] P1_CFG_RST = 16'h0000;
	localparam logic [15:0] P2_CFG_RST = 16'h0004;
	localparam logic [15:0] P2_TIMING_RST = 16'h0064;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int MS_NS = 1_000_000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int LAMP_HOLD_MS = 50;
	localparam int LAMP_CYCLES = LAMP_HOLD_MS * MS_CYCLES;
	localparam logic [27:0] GAP_BITS = 28'h0000023;
	localparam logic [7:0] ENQ_CODE = 8'h05;
	localparam logic [7:0] HOST_LEAD = 8'h4E;
	localparam logic [7:0] NODE_MAX = 8'hF7;

	typedef enum logic [1:0] {
		T2_IDLE = 2'b00,
		T2_RTS = 2'b01,
		T2_SEND = 2'b11,
		T2_DRAIN = 2'b10
	} tx2_state_t;

	typedef enum logic [1:0] {
		PROTO_NONE = 2'b00,
		PROTO_HOST = 2'b01,
		PROTO_MODBUS = 2'b10,
		PROTO_RAW = 2'b11
	} proto_t;

	// ---------------------------------------------------------------
	// bit-rate dividers
	// ---------------------------------------------------------------
	function automatic logic [DIV_W-1:0] rate_div(input int rate);
		return DIV_W'(CLK_HZ / rate);
	endfunction : rate_div

	function automatic logic [DIV_W-1:0] p1_div(input logic [2:0] sel);
		case (sel)
			3'h1: return rate_div(19200);
			3'h2: return rate_div(38400);
			3'h3: return rate_div(57600);
			3'h4: return rate_div(115200);
			default: return rate_div(9600);
		endcase
	endfunction : p1_div

	function automatic logic [DIV_W-1:0] p2_div(input logic [3:0] sel);
		case (sel)
			4'h0: return rate_div(300);
			4'h1: return rate_div(600);
			4'h2: return rate_div(1200);
			4'h3: return rate_div(4800);
			4'h5: return rate_div(19200);
			4'h6: return rate_div(38400);
			4'h7: return rate_div(57600);
			4'h8: return rate_div(115200);
			default: return rate_div(9600);
		endcase
	endfunction : p2_div

	function automatic proto_t classify(input logic [7:0] b,
		input logic raw_en);
		if (raw_en)
			return PROTO_RAW;
		if (b == ENQ_CODE || b == HOST_LEAD)
			return PROTO_HOST;
		if (b != 8'h00 && b <= NODE_MAX)
			return PROTO_MODBUS;
		return PROTO_RAW;
	endfunction : classify
endpackage : dcm_pkg

// File: verilog/dual_port_serial_comm_module.sv
`timescale 1ns/1ps
module dual_port_serial_comm_module #(
	parameter int unsigned MS_CYCLES = dcm_pkg::MS_CYCLES,
	parameter int unsigned LAMP_CYCLES = dcm_pkg::LAMP_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [dcm_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dcm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [dcm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic first_port_serial_in,
	output logic first_port_serial_out,
	input wire logic second_port_serial_in,
	output logic second_port_serial_out,
	output logic second_port_send_request,
	input wire logic second_port_send_permit,
	output logic first_port_send_lamp,
	output logic first_port_receive_lamp,
	output logic first_port_error_lamp,
	output logic second_port_send_lamp,
	output logic second_port_receive_lamp,
	output logic second_port_error_lamp
);
	import dcm_pkg::*;

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	logic [15:0] p1_cfg_q, p2_cfg_q, timing_q;
	logic [8:0] rx1_q, rx2_q;
	logic [7:0] tx2_byte_q;
	logic pend_q, pend_last_q, last_sent_q;
	logic master_q, wait_q, rts_q;
	logic tmo_err_q, fe1_q, fe2_q, msg_start_q;
	logic [7:0] dly_q, resp_cnt_q;
	logic [23:0] ms_cnt_q;
	logic [27:0] gap_q;
	logic [15:0] rdata_q;
	tx2_state_t st_q;
	proto_t proto_q;
	logic tx1_ready, tx2_ready, rx1_busy, rx2_busy;
	logic rx1_valid, rx2_valid, rx1_fe, rx2_fe;
	logic [7:0] rx1_data, rx2_data;

	// ---------------------------------------------------------------
	// register decode
	// ---------------------------------------------------------------
	wire wr_p1 = reg_wr && reg_addr == REG_P1_CFG;
	wire wr_p2 = reg_wr && reg_addr == REG_P2_CFG;
	wire wr_tim = reg_wr && reg_addr == REG_P2_TIMING;
	wire wr_tx1 = reg_wr && reg_addr == REG_TX1;
	wire wr_tx2 = reg_wr && reg_addr == REG_TX2;
	wire wr_ctrl = reg_wr && reg_addr == REG_CTRL;
	wire wr_st = reg_wr && reg_addr == REG_STATUS;
	wire wr_rep = reg_wr && reg_addr == REG_REPORT;
	wire rd_rx1 = reg_rd && reg_addr == REG_RX1;
	wire rd_rx2 = reg_rd && reg_addr == REG_RX2;

	// ---------------------------------------------------------------
	// port settings
	// ---------------------------------------------------------------
	wire [DIV_W-1:0] div1 = p1_div(p1_cfg_q[2:0]);
	wire [DIV_W-1:0] div2 = p2_div(p2_cfg_q[3:0]);
	wire data7_2 = p2_cfg_q[P2_DATA7_BIT];
	wire stop2_2 = p2_cfg_q[P2_STOP2_BIT];
	wire master_cfg = p2_cfg_q[P2_MASTER_BIT];
	wire raw_en = p2_cfg_q[P2_RAW_BIT];
	wire [7:0] tmo_ms = timing_q[7:0];
	wire [7:0] rts_dly = timing_q[15:8];

	// configuration registers start at working defaults
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			p1_cfg_q <= P1_CFG_RST;
			p2_cfg_q <= P2_CFG_RST;
			timing_q <= P2_TIMING_RST;
		end else begin
			if (wr_p1)
				p1_cfg_q <= {13'h0000, reg_wdata[2:0]};
			if (wr_p2)
				p2_cfg_q <= {8'h00, reg_wdata[7:0]};
			if (wr_tim)
				timing_q <= reg_wdata;
		end
	end

	// ---------------------------------------------------------------
	// millisecond tick
	// ---------------------------------------------------------------
	wire ms_tick = (ms_cnt_q == 24'(MS_CYCLES - 1));

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ms_cnt_q <= 24'h000000;
		else
			ms_cnt_q <= ms_tick ? 24'h000000 : ms_cnt_q + 24'h000001;
	end

	// ---------------------------------------------------------------
	// serial engines
	// ---------------------------------------------------------------
	// port one framing is hard wired: eight data, one stop
	serial_tx #(.DIV_W(DIV_W)) u_tx1 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.bit_div(div1),
		.data7(1'b0),
		.stop2(1'b0),
		.start(wr_tx1 && tx1_ready),
		.data(reg_wdata[7:0]),
		.ready(tx1_ready),
		.line(first_port_serial_out)
	);

	serial_rx #(.DIV_W(DIV_W)) u_rx1 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.bit_div(div1),
		.data7(1'b0),
		.line(first_port_serial_in),
		.busy(rx1_busy),
		.valid(rx1_valid),
		.data(rx1_data),
		.frame_err(rx1_fe)
	);

	// transmit waits for the partner's permit; tie it high if unused
	wire start2 = st_q == T2_SEND && pend_q && tx2_ready
		&& second_port_send_permit;

	serial_tx #(.DIV_W(DIV_W)) u_tx2 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.bit_div(div2),
		.data7(data7_2),
		.stop2(stop2_2),
		.start(start2),
		.data(tx2_byte_q),
		.ready(tx2_ready),
		.line(second_port_serial_out)
	);

	serial_rx #(.DIV_W(DIV_W)) u_rx2 (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.bit_div(div2),
		.data7(data7_2),
		.line(second_port_serial_in),
		.busy(rx2_busy),
		.valid(rx2_valid),
		.data(rx2_data),
		.frame_err(rx2_fe)
	);

	// ---------------------------------------------------------------
	// port two send sequencing
	// ---------------------------------------------------------------
	wire drain_done = st_q == T2_DRAIN && tx2_ready;
	wire tmo_evt = wait_q && ms_tick
		&& (9'(resp_cnt_q) + 9'h001 >= {1'b0, tmo_ms});

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= T2_IDLE;
			rts_q <= 1'b0;
			dly_q <= 8'h00;
			last_sent_q <= 1'b0;
		end else begin
			unique case (st_q)
				T2_IDLE: begin
					if (pend_q) begin
						rts_q <= 1'b1;
						dly_q <= rts_dly;
						st_q <= T2_RTS;
					end
				end
				T2_RTS: begin
					if (dly_q == 8'h00)
						st_q <= T2_SEND;
					else if (ms_tick)
						dly_q <= dly_q - 8'h01;
				end
				T2_SEND: begin
					if (start2) begin
						last_sent_q <= pend_last_q;
						st_q <= T2_DRAIN;
					end
				end
				T2_DRAIN: begin
					if (tx2_ready) begin
						st_q <= pend_q ? T2_SEND : T2_IDLE;
						rts_q <= pend_q;
					end
				end
			endcase
		end
	end

	// one byte of holding; a write while full is dropped
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
			pend_last_q <= 1'b0;
			tx2_byte_q <= 8'h00;
		end else if (wr_tx2 && !pend_q) begin
			pend_q <= 1'b1;
			pend_last_q <= reg_wdata[TX2_LAST_BIT];
			tx2_byte_q <= reg_wdata[7:0];
		end else if (start2) begin
			pend_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// master mode and response timer
	// ---------------------------------------------------------------
	// master only granted once software has set the master bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			master_q <= 1'b0;
			wait_q <= 1'b0;
			resp_cnt_q <= 8'h00;
		end else begin
			if (wr_ctrl && reg_wdata[CTRL_END_BIT] || tmo_evt)
				master_q <= 1'b0;
			else if (wr_ctrl && reg_wdata[CTRL_START_BIT] && master_cfg)
				master_q <= 1'b1;
			if (drain_done && last_sent_q && master_q) begin
				wait_q <= 1'b1;
				resp_cnt_q <= 8'h00;
			end else if (rx2_valid || tmo_evt || !master_q) begin
				wait_q <= 1'b0;
			end else if (wait_q && ms_tick) begin
				resp_cnt_q <= resp_cnt_q + 8'h01;
			end
		end
	end

	// ---------------------------------------------------------------
	// protocol detection on port two
	// ---------------------------------------------------------------
	wire [27:0] gap_lim = GAP_BITS * {8'h00, div2};

	// first byte after a quiet gap names the protocol
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			gap_q <= 28'h0000000;
			msg_start_q <= 1'b1;
			proto_q <= PROTO_NONE;
		end else begin
			if (rx2_busy)
				gap_q <= 28'h0000000;
			else if (gap_q < gap_lim)
				gap_q <= gap_q + 28'h0000001;
			if (rx2_valid && msg_start_q) begin
				proto_q <= classify(rx2_data, raw_en);
				msg_start_q <= 1'b0;
			end else if (gap_q >= gap_lim) begin
				msg_start_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// receive holding and sticky flags
	// ---------------------------------------------------------------
	// new data beats a read in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rx1_q <= 9'h000;
			rx2_q <= 9'h000;
			tmo_err_q <= 1'b0;
			fe1_q <= 1'b0;
			fe2_q <= 1'b0;
		end else begin
			if (rx1_valid)
				rx1_q <= {1'b1, rx1_data};
			else if (rd_rx1)
				rx1_q[RX_VALID_BIT] <= 1'b0;
			if (rx2_valid)
				rx2_q <= {1'b1, rx2_data};
			else if (rd_rx2)
				rx2_q[RX_VALID_BIT] <= 1'b0;
			if (tmo_evt)
				tmo_err_q <= 1'b1;
			else if (wr_st && reg_wdata[ST_TMO_BIT])
				tmo_err_q <= 1'b0;
			if (rx1_fe)
				fe1_q <= 1'b1;
			else if (wr_st && reg_wdata[ST_FE1_BIT])
				fe1_q <= 1'b0;
			if (rx2_fe)
				fe2_q <= 1'b1;
			else if (wr_st && reg_wdata[ST_FE2_BIT])
				fe2_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	wire [15:0] status = {3'b000, pend_q, fe2_q, fe1_q, rx2_q[8], rx1_q[8],
		proto_q, 1'b0, tmo_err_q, wait_q, master_q,
		st_q != T2_IDLE, !tx1_ready};
	wire [15:0] rd_mux =
		reg_addr == REG_P1_CFG ? p1_cfg_q :
		reg_addr == REG_P2_CFG ? p2_cfg_q :
		reg_addr == REG_P2_TIMING ? timing_q :
		reg_addr == REG_RX1 ? {7'h00, rx1_q} :
		reg_addr == REG_RX2 ? {7'h00, rx2_q} :
		reg_addr == REG_STATUS ? status : 16'h0000;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= 16'h0000;
		else if (reg_rd)
			rdata_q <= rd_mux;
		else
			rdata_q <= 16'h0000;
	end

	assign reg_rdata = rdata_q;
	assign second_port_send_request = rts_q;

	// ---------------------------------------------------------------
	// indicator lamps
	// ---------------------------------------------------------------
	// nak and exception are decoded by software and reported here
	wire err1 = wr_rep && |reg_wdata[2:0];
	wire err2 = wr_rep && |reg_wdata[4:3] || tmo_evt;
	wire [5:0] lamp_evt = {err2, rx2_busy, !tx2_ready,
		err1, rx1_busy, !tx1_ready};
	logic [5:0] lamp_q;
	logic [22:0] hold_q [6];

	for (genvar i = 0; i < 6; i++) begin : g_lamp
		always_ff @(posedge clk_sys or negedge rst_n) begin
			if (!rst_n) begin
				lamp_q[i] <= 1'b0;
				hold_q[i] <= 23'h000000;
			end else if (lamp_evt[i]) begin
				lamp_q[i] <= 1'b1;
				hold_q[i] <= 23'(LAMP_CYCLES - 1);
			end else if (hold_q[i] != 23'h000000) begin
				hold_q[i] <= hold_q[i] - 23'h000001;
			end else begin
				lamp_q[i] <= 1'b0;
			end
		end
	end

	assign first_port_send_lamp = lamp_q[0];
	assign first_port_receive_lamp = lamp_q[1];
	assign first_port_error_lamp = lamp_q[2];
	assign second_port_send_lamp = lamp_q[3];
	assign second_port_receive_lamp = lamp_q[4];
	assign second_port_error_lamp = lamp_q[5];
endmodule : dual_port_serial_comm_module

// File: verilog/serial_rx.sv
`timescale 1ns/1ps
module serial_rx #(
	parameter int DIV_W = 20
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [DIV_W-1:0] bit_div,
	input wire logic data7,
	input wire logic line,
	output logic busy,
	output logic valid,
	output logic [7:0] data,
	output logic frame_err
);
	logic prev_q, busy_q, valid_q, ferr_q;
	logic [DIV_W-1:0] cnt_q;
	logic [3:0] bits_q;
	logic [7:0] shift_q, data_q;
	wire [3:0] nd = data7 ? 4'h7 : 4'h8;
	wire bit_end = (cnt_q == '0);

	// mid-bit sampling: first wait is half a bit
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 1'b1;
			busy_q <= 1'b0;
			valid_q <= 1'b0;
			ferr_q <= 1'b0;
			cnt_q <= '0;
			bits_q <= 4'h0;
			shift_q <= 8'h00;
			data_q <= 8'h00;
		end else begin
			prev_q <= line;
			valid_q <= 1'b0;
			ferr_q <= 1'b0;
			if (!busy_q) begin
				if (prev_q && !line) begin
					busy_q <= 1'b1;
					cnt_q <= bit_div >> 1;
					bits_q <= 4'h0;
				end
			end else if (!bit_end) begin
				cnt_q <= cnt_q - 1'b1;
			end else begin
				cnt_q <= bit_div - 1'b1;
				bits_q <= bits_q + 4'h1;
				if (bits_q == 4'h0 && line)
					busy_q <= 1'b0;
				else if (bits_q != 4'h0 && bits_q <= nd)
					shift_q <= {line, shift_q[7:1]};
				else if (bits_q > nd) begin
					busy_q <= 1'b0;
					valid_q <= line;
					ferr_q <= !line;
					data_q <= data7 ? {1'b0, shift_q[7:1]} : shift_q;
				end
			end
		end
	end

	assign busy = busy_q;
	assign valid = valid_q;
	assign data = data_q;
	assign frame_err = ferr_q;
endmodule : serial_rx

// File: verilog/serial_tx.sv
`timescale 1ns/1ps
module serial_tx #(
	parameter int DIV_W = 20
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [DIV_W-1:0] bit_div,
	input wire logic data7,
	input wire logic stop2,
	input wire logic start,
	input wire logic [7:0] data,
	output logic ready,
	output logic line
);
	logic busy_q, line_q;
	logic [DIV_W-1:0] cnt_q;
	logic [3:0] left_q;
	logic [9:0] shift_q;
	// seven-bit mode pads with a one, which doubles as a stop bit
	wire [7:0] d8 = data7 ? {1'b1, data[6:0]} : data;
	wire [3:0] nbits = (data7 ? 4'h7 : 4'h8) + (stop2 ? 4'h2 : 4'h1);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			line_q <= 1'b1;
			cnt_q <= '0;
			left_q <= 4'h0;
			shift_q <= 10'h3FF;
		end else if (!busy_q) begin
			if (start) begin
				busy_q <= 1'b1;
				line_q <= 1'b0;
				cnt_q <= bit_div - 1'b1;
				left_q <= nbits;
				shift_q <= {2'b11, d8};
			end
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end else if (left_q == 4'h0) begin
			busy_q <= 1'b0;
		end else begin
			cnt_q <= bit_div - 1'b1;
			line_q <= shift_q[0];
			shift_q <= {1'b1, shift_q[9:1]};
			left_q <= left_q - 4'h1;
		end
	end

	assign ready = !busy_q;
	assign line = line_q;
endmodule : serial_tx
